/* logic/interrupt_enable_priority_ctrl.sv */
// Interrupt enable and priority controller with Wishbone register access
// Behaviour
// - Fourteen sources gated by two enable registers
// - Enable bit one permits, zero blocks
// - First enable bit 7 is master switch
// - Bit 5 gates LIN identifier, bit 4 serial
// - Bit 3 timer one, bit 1 timer zero
// - Bit 2 pin two, bit 0 pin one
// - Second enable bits 0-2 gate sources 6-8
// - Second enable bits 3-7 gate sources 9-13
// - Priority bit one high, zero low
// - Handler preempted only by strictly higher priority
// - First priority mirrors enable; bits 7-6 zero
// - Second priority bits map sources 6-13
// - Enable bit 6 reads zero; all reset zero
// - Serial request is transmit-done or receive-done
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module interrupt_enable_priority_ctrl (
	input  wire logic                                   clk_i,
	input  wire logic                                   rst_i,
	input  wire logic                                   ce_i,
	input  wire logic                                   wb_cyc_i,
	input  wire logic                                   wb_stb_i,
	input  wire logic                                   wb_we_i,
	input  wire logic [irq_ctrl_pkg::ADR_W-1:0]         wb_adr_i,
	input  wire logic [irq_ctrl_pkg::SEL_W-1:0]         wb_sel_i,
	input  wire logic [irq_ctrl_pkg::DAT_W-1:0]         wb_dat_i,
	output logic      [irq_ctrl_pkg::DAT_W-1:0]         wb_dat_o,
	output logic                                        wb_ack_o,
	input  wire logic                                   irq_pin_first_i,
	input  wire logic                                   irq_pin_second_i,
	input  wire logic                                   timer_zero_ovf_i,
	input  wire logic                                   timer_one_ovf_i,
	input  wire logic                                   tx_done_flag_i,
	input  wire logic                                   rx_done_flag_i,
	input  wire logic [irq_ctrl_pkg::DEV_SRC_N-1:0]     dev_req_i,
	input  wire irq_ctrl_pkg::core_ack_t                core_ack_i,
	output irq_ctrl_pkg::int_req_t                      int_req_o,
	output logic                                        irq_o
);
	import irq_ctrl_pkg::*;

	// Software-visible registers
	logic [REG_W-1:0] int_enable_reg_first;    // Master switch and sources 0..5
	logic [REG_W-1:0] int_enable_reg_second;   // Sources 6..13
	logic [REG_W-1:0] int_priority_reg_first;  // Priorities of sources 0..5
	logic [REG_W-1:0] int_priority_reg_second; // Priorities of sources 6..13
	logic [SRC_N-1:0] event_status;            // Sticky request-arrival flags
	logic [SRC_N-1:0] event_mask;              // Gates status onto irq_o

	// Request side
	logic [SRC_N-1:0] req_vec;                 // Pending requests, by source number
	logic [SRC_N-1:0] req_prev;                // Last sampled requests, for edge finding
	logic [SRC_N-1:0] req_rise;                // New arrivals this cycle
	logic [SRC_N-1:0] enable_vec;              // Per-source enables
	logic [SRC_N-1:0] prio_vec;                // Per-source priority levels
	logic             global_int_enable;       // Master switch
	logic [SRC_N-1:0] eligible;                // Pending, enabled and globally on
	logic [SRC_N-1:0] high_elig;               // Eligible at high priority
	logic [SRC_N-1:0] low_elig;                // Eligible at low priority
	logic             high_found;
	logic             low_found;
	logic [SRC_W-1:0] high_idx;
	logic [SRC_W-1:0] low_idx;

	// Arbitration result
	svc_t             svc_state;               // What the core is servicing now
	logic             next_valid;
	logic             next_high;
	logic [SRC_W-1:0] next_source;

	// Bus decode
	logic             bus_req;                 // Active request: cycle and strobe both high
	logic             bus_wr;                  // Write commits on the ack edge
	logic [DAT_W-1:0] rd_mux;                  // Read data for the addressed word
	logic [SRC_N-1:0] w1c_bits;                // Status bits software clears

	// Serial source is the OR of the two completion flags
	always_comb begin
		req_vec = {dev_req_i,
			tx_done_flag_i | rx_done_flag_i,
			timer_one_ovf_i,
			irq_pin_second_i,
			timer_zero_ovf_i,
			irq_pin_first_i};
	end

	// Flatten registers into source-indexed vectors
	always_comb begin
		global_int_enable = int_enable_reg_first[GLOBAL_EN_BIT];
		enable_vec = {int_enable_reg_second,
			int_enable_reg_first[FIRST_SRC_N-1:0]};
		prio_vec = {int_priority_reg_second,
			int_priority_reg_first[FIRST_SRC_N-1:0]};
	end

	// Only pending, enabled sources compete, and only with the master switch on
	always_comb begin
		eligible = req_vec & enable_vec & {SRC_N{global_int_enable}};
		high_elig = eligible & prio_vec;
		low_elig = eligible & ~prio_vec;
	end

	// Fixed-order choice inside each priority level
	pick_first #(
		.W  (SRC_N),
		.IW (SRC_W)
	) u_pick_high (
		.vec_i   (high_elig),
		.found_o (high_found),
		.idx_o   (high_idx)
	);

	pick_first #(
		.W  (SRC_N),
		.IW (SRC_W)
	) u_pick_low (
		.vec_i   (low_elig),
		.found_o (low_found),
		.idx_o   (low_idx)
	);

	// Offer only what may preempt the handler now running
	always_comb begin
		next_valid = 1'b0;
		next_high = 1'b0;
		next_source = '0;
		case (svc_state)
			svc_none: begin
				// Idle core: high level first, then low
				if (high_found) begin
					next_valid = 1'b1;
					next_high = 1'b1;
					next_source = high_idx;
				end else if (low_found) begin
					next_valid = 1'b1;
					next_source = low_idx;
				end
			end
			svc_low: begin
				// Low handler: only a high request may cut in
				if (high_found) begin
					next_valid = 1'b1;
					next_high = 1'b1;
					next_source = high_idx;
				end
			end
			svc_high, svc_both: begin
				// Nothing outranks high, so nothing is offered
				next_valid = 1'b0;
			end
			default: begin
				next_valid = 1'b0;
			end
		endcase
	end

	// Offer register; cleared on the take cycle so a stale vector is never seen
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_req_o <= '0;
		end else if (ce_i) begin
			if (core_ack_i.taken) begin
				int_req_o <= '0;
			end else begin
				int_req_o.valid <= next_valid;
				int_req_o.high <= next_high;
				int_req_o.source <= next_source;
			end
		end
	end

	// Nesting of handlers; a high take from low stacks both levels
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			svc_state <= svc_none;
		end else if (ce_i) begin
			case (svc_state)
				svc_none: begin
					if (core_ack_i.taken && int_req_o.valid) begin
						svc_state <= int_req_o.high ? svc_high : svc_low;
					end
				end
				svc_low: begin
					// Preemption wins over a return in the same cycle
					if (core_ack_i.taken && int_req_o.valid && int_req_o.high) begin
						svc_state <= svc_both;
					end else if (core_ack_i.done) begin
						svc_state <= svc_none;
					end
				end
				svc_high: begin
					if (core_ack_i.done) begin
						svc_state <= svc_none;
					end
				end
				svc_both: begin
					// Returning from the inner handler resumes the low one
					if (core_ack_i.done) begin
						svc_state <= svc_low;
					end
				end
				default: begin
					svc_state <= svc_none;
				end
			endcase
		end
	end

	// Wishbone handshake terms
	always_comb begin
		bus_req = wb_cyc_i & wb_stb_i;
		bus_wr = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
		w1c_bits = '0;
		if (bus_req && wb_we_i && wb_ack_o && wb_adr_i == STATUS_OFF) begin
			w1c_bits[REG_W-1:0] = wb_sel_i[0] ? wb_dat_i[REG_W-1:0] : '0;
			w1c_bits[SRC_N-1:REG_W] = wb_sel_i[1] ? wb_dat_i[SRC_N-1:REG_W] : '0;
		end
	end

	// Read mux; unmapped words read as zero
	always_comb begin
		rd_mux = '0;
		case (wb_adr_i)
			IE_FIRST_OFF:  rd_mux[REG_W-1:0] = int_enable_reg_first;
			IP_FIRST_OFF:  rd_mux[REG_W-1:0] = int_priority_reg_first;
			IE_SECOND_OFF: rd_mux[REG_W-1:0] = int_enable_reg_second;
			IP_SECOND_OFF: rd_mux[REG_W-1:0] = int_priority_reg_second;
			STATUS_OFF:    rd_mux[SRC_N-1:0] = event_status;
			MASK_OFF:      rd_mux[SRC_N-1:0] = event_mask;
			default:       rd_mux = '0;
		endcase
	end

	// One-wait-state answer; data registered with the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else if (ce_i) begin
			wb_ack_o <= bus_req & ~wb_ack_o;
			if (bus_req && !wb_ack_o) begin
				wb_dat_o <= rd_mux;
			end
		end
	end

	// Enable registers; bit 6 of the first is hard zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_enable_reg_first <= REG_RESET;
			int_enable_reg_second <= REG_RESET;
		end else if (ce_i && bus_wr) begin
			if (wb_adr_i == IE_FIRST_OFF) begin
				int_enable_reg_first <= wb_dat_i[REG_W-1:0];
				int_enable_reg_first[IE_ZERO_BIT] <= 1'b0;
			end
			if (wb_adr_i == IE_SECOND_OFF) begin
				int_enable_reg_second <= wb_dat_i[REG_W-1:0];
			end
		end
	end

	// Priority registers; top two bits of the first are hard zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_priority_reg_first <= REG_RESET;
			int_priority_reg_second <= REG_RESET;
		end else if (ce_i && bus_wr) begin
			if (wb_adr_i == IP_FIRST_OFF) begin
				int_priority_reg_first <= wb_dat_i[REG_W-1:0];
				int_priority_reg_first[IP_ZERO_HI:IP_ZERO_LO] <= '0;
			end
			if (wb_adr_i == IP_SECOND_OFF) begin
				int_priority_reg_second <= wb_dat_i[REG_W-1:0];
			end
		end
	end

	// Mask register, both low bytes writable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			event_mask <= FLAG_RESET;
		end else if (ce_i && bus_req && wb_we_i && wb_ack_o && wb_adr_i == MASK_OFF) begin
			if (wb_sel_i[0]) begin
				event_mask[REG_W-1:0] <= wb_dat_i[REG_W-1:0];
			end
			if (wb_sel_i[1]) begin
				event_mask[SRC_N-1:REG_W] <= wb_dat_i[SRC_N-1:REG_W];
			end
		end
	end

	// Arrival edges; a level held high counts once
	always_comb begin
		req_rise = req_vec & ~req_prev;
	end

	// Sticky status; a new arrival beats a same-cycle clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_prev <= FLAG_RESET;
			event_status <= FLAG_RESET;
		end else if (ce_i) begin
			req_prev <= req_vec;
			event_status <= (event_status & ~w1c_bits) | req_rise;
		end
	end

	// Summary line for software polling without the core vector path
	always_comb begin
		irq_o = |(event_status & event_mask);
	end

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	master_switch_off_a: assert property (
		ce_i && !global_int_enable |=> !int_req_o.valid)
		else $error("vector offered with master switch off");

	offer_has_cause_a: assert property (
		$rose(int_req_o.valid) |-> $past(eligible != '0))
		else $error("vector offered with no eligible source");

	high_blocks_all_a: assert property (
		(svc_state == svc_high || svc_state == svc_both) |-> !int_req_o.valid)
		else $error("vector offered during high handler");

	low_only_high_a: assert property (
		svc_state == svc_low && int_req_o.valid |-> int_req_o.high)
		else $error("low vector offered during low handler");

	high_before_low_a: assert property (
		ce_i && high_found && svc_state == svc_none && !core_ack_i.taken
		|=> int_req_o.valid && int_req_o.high)
		else $error("high request not preferred");

	ie_bit_six_a: assert property (
		wb_ack_o && $past(wb_adr_i) == IE_FIRST_OFF |-> !wb_dat_o[IE_ZERO_BIT])
		else $error("first enable bit 6 not zero");

	ip_top_zero_a: assert property (
		wb_ack_o && $past(wb_adr_i) == IP_FIRST_OFF
		|-> wb_dat_o[IP_ZERO_HI:IP_ZERO_LO] == '0)
		else $error("first priority bits 7-6 not zero");

	reset_clears_a: assert property (
		$fell(rst_i) |-> int_enable_reg_first == '0 && int_priority_reg_second == '0
		&& int_enable_reg_second == '0 && int_priority_reg_first == '0)
		else $error("registers not cleared by reset");

	serial_flag_a: assert property (
		ce_i && (tx_done_flag_i || rx_done_flag_i) && !req_prev[SERIAL_SRC]
		|=> event_status[SERIAL_SRC])
		else $error("serial flag did not raise request");

	// A frozen clock enable legally holds ack, so only a running cycle counts
	ack_one_cycle_a: assert property (
		wb_ack_o && ce_i |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
endmodule : interrupt_enable_priority_ctrl

/* logic/irq_ctrl_pkg.sv */
// Shared constants, carriers and state type of the interrupt enable and priority block
package irq_ctrl_pkg;
	// Source count and index width
	localparam int SRC_N = 14;
	localparam int SRC_W = 4;
	localparam int FIRST_SRC_N = 6;           // Sources 0..5 live in the first registers
	localparam int SECOND_SRC_N = 8;          // Sources 6..13 live in the second registers
	localparam int DEV_SRC_N = 9;             // Device-specific sources 5..13
	localparam int SERIAL_SRC = 4;            // Serial port source index

	// Bus geometry
	localparam int ADR_W = 9;
	localparam int DAT_W = 32;
	localparam int SEL_W = 4;
	localparam int REG_W = 8;

	// Register byte addresses
	localparam logic [ADR_W-1:0] IE_FIRST_OFF  = 9'h0a8;
	localparam logic [ADR_W-1:0] IP_FIRST_OFF  = 9'h0b8;
	localparam logic [ADR_W-1:0] IE_SECOND_OFF = 9'h0e8;
	localparam logic [ADR_W-1:0] IP_SECOND_OFF = 9'h0f8;
	localparam logic [ADR_W-1:0] STATUS_OFF    = 9'h100;
	localparam logic [ADR_W-1:0] MASK_OFF      = 9'h104;

	// Field positions
	localparam int GLOBAL_EN_BIT = 7;         // Master switch in first enable register
	localparam int IE_ZERO_BIT   = 6;         // Read-only zero in first enable register
	localparam int IP_ZERO_HI    = 7;         // Read-only zero field of first priority register
	localparam int IP_ZERO_LO    = 6;

	// Reset values
	localparam logic [REG_W-1:0] REG_RESET  = 8'h00;
	localparam logic [SRC_N-1:0] FLAG_RESET = 14'h0000;

	// Request to the processor core
	typedef struct packed {
		logic             valid;              // A vector is offered
		logic             high;               // Offered vector is high priority
		logic [SRC_W-1:0] source;             // Offered source number
	} int_req_t;

	// Answer from the processor core
	typedef struct packed {
		logic taken;                          // Core enters the offered handler
		logic done;                           // Core returns from the current handler
	} core_ack_t;

	// Service nesting
	typedef enum logic [1:0] {
		svc_none,
		svc_low,
		svc_high,
		svc_both
	} svc_t;
endpackage : irq_ctrl_pkg

/* logic/pick_first.sv */
// Fixed-order picker: lowest set bit wins
`timescale 1ns/1ps
module pick_first #(
	parameter int W  = 14,
	parameter int IW = 4
) (
	input  wire logic [W-1:0]  vec_i,
	output logic               found_o,
	output logic [IW-1:0]      idx_o
);
	// Scan downward so the lowest index is written last
	always_comb begin
		found_o = |vec_i;
		idx_o = '0;
		for (int i = W - 1; i >= 0; i--) begin
			if (vec_i[i]) begin
				idx_o = IW'(i);
			end
		end
	end
endmodule : pick_first

/* tb/core_model.sv */
// Processor core stand-in: accepts offered vectors and returns from handlers
`timescale 1ns/1ps
module core_model (
	input  wire logic                   clk_i,  // System clock
	input  wire logic                   rst_i,  // Synchronous reset
	input  wire irq_ctrl_pkg::int_req_t req_i,  // Vector offered by the block
	input  wire logic                   hold_i, // Stall: leave offers unanswered
	input  wire logic                   ret_i,  // Leave the current handler
	output irq_ctrl_pkg::core_ack_t     ack_o   // Accept and return pulses
);
	import irq_ctrl_pkg::*;

	// Accept one cycle after an offer; guard keeps taken a single pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= '0;
		end else begin
			ack_o.taken <= req_i.valid && !hold_i && !ack_o.taken;
			ack_o.done  <= ret_i;
		end
	end
endmodule : core_model

/* tb/tb_top.sv */
// Self-checking bench for the interrupt enable and priority block
`timescale 1ns/1ps
module tb_top;
	import irq_ctrl_pkg::*;
	logic             clk_i;      // 50 MHz clock
	logic             rst_i;      // Synchronous reset
	logic             cyc;        // Bus cycle
	logic             stb;        // Bus strobe
	logic             we;         // Write flag
	logic [ADR_W-1:0] adr;        // Byte address
	logic [DAT_W-1:0] wdat;       // Write data
	logic [DAT_W-1:0] rdat;       // Read data taken at ack
	logic [DAT_W-1:0] dat_o;      // Read data bus
	logic             ack;        // Bus acknowledge
	logic [SRC_N-1:0] src;        // Request levels, one per source
	logic [SRC_N-1:0] en;         // Enable pattern under test
	logic             rx;         // Second serial flag
	logic             hold;       // Core stall
	logic             ret;        // Core return request
	core_ack_t        cack;       // Core answers
	int_req_t         req;        // Offered vector
	logic             irq;        // Level interrupt
	int               num_errors; // Mismatches
	int               checks;     // Comparisons made
	logic [ADR_W-1:0] regs [4];   // Register table
	logic [DAT_W-1:0] ones [4];   // Readback after writing all ones

	interrupt_enable_priority_ctrl DUT (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.irq_pin_first_i(src[0]), .timer_zero_ovf_i(src[1]),
		.irq_pin_second_i(src[2]), .timer_one_ovf_i(src[3]),
		.tx_done_flag_i(src[4]), .rx_done_flag_i(rx), .dev_req_i(src[13:5]),
		.core_ack_i(cack), .int_req_o(req), .irq_o(irq)
	);

	core_model core (
		.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .hold_i(hold), .ret_i(ret), .ack_o(cack)
	);

	// Free-running clock
	always #10 clk_i = ~clk_i;

	// Count and report a comparison
	task automatic chk(input logic [DAT_W-1:0] seen, input logic [DAT_W-1:0] exp,
			input string what);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask : chk

	// One classic cycle; request held until ack is seen at an edge
	task automatic bus(input logic [ADR_W-1:0] a, input logic w, input logic [DAT_W-1:0] d);
		int n;
		n = 0;
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rdat = dat_o;
		chk(ack, 1'b1, "bus ack");
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		@(posedge clk_i);
	endtask : bus

	// Register read against an expected value
	task automatic rd(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] exp);
		bus(a, 1'b0, '0);
		chk(rdat, exp, "read data");
	endtask : rd

	// Wait for an offer (stalled core) or a take, then check the vector
	task automatic offer(input logic [SRC_W-1:0] s, input logic hi);
		int n;
		n = 0;
		while ((hold ? req.valid : cack.taken) !== 1'b1 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		chk(req.valid, 1'b1, "offer valid");
		chk(req.source, s, "offer source");
		chk(req.high, hi, "offer level");
	endtask : offer

	// Nothing may be offered after a settling span
	task automatic quiet(input int n);
		repeat (n) @(posedge clk_i);
		chk(req.valid, 1'b0, "no offer");
	endtask : quiet

	// One-cycle return from the current handler
	task automatic leave;
		ret <= 1'b1;
		@(posedge clk_i);
		ret <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask : leave

	// Single place where the run ends
	task automatic final_report;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report

	// Watchdog far beyond the expected few hundred cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		final_report();
	end

	// Main sequence
	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		{cyc, stb, we, adr, wdat} = '0;
		{src, rx, hold, ret} = '0;
		num_errors = 0;
		checks = 0;
		regs = '{IE_FIRST_OFF, IP_FIRST_OFF, IE_SECOND_OFF, IP_SECOND_OFF};
		ones = '{32'hbf, 32'h3f, 32'hff, 32'hff};
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// Reset values, read-only zeros, upper bits of each word
		for (int i = 0; i < 4; i++) begin
			rd(regs[i], '0);
			bus(regs[i], 1'b1, 32'hffffffff);
			rd(regs[i], ones[i]);
		end
		bus(9'h0c0, 1'b1, 32'hff);
		rd(9'h0c0, '0);
		// Every source: own bit off blocks, on passes, master off blocks
		hold <= 1'b1;
		for (int s = 0; s < SRC_N; s++) begin
			en = 14'h3fff & ~(14'h1 << s);
			bus(IE_FIRST_OFF, 1'b1, {24'h0, 2'b10, en[5:0]});
			bus(IE_SECOND_OFF, 1'b1, {24'h0, en[13:6]});
			src <= 14'h1 << s;
			quiet(4);
			bus(s < 6 ? IE_FIRST_OFF : IE_SECOND_OFF, 1'b1, 32'hff);
			offer(SRC_W'(s), 1'b1);
			bus(IE_FIRST_OFF, 1'b1, 32'h3f);
			quiet(3);
			src <= '0;
		end
		// Same level: lowest number wins; a high source beats lower-numbered low ones
		bus(IP_SECOND_OFF, 1'b1, 32'h0);
		src <= 14'h2900;
		bus(IE_FIRST_OFF, 1'b1, 32'h80);
		offer(4'd8, 1'b0);
		bus(IP_SECOND_OFF, 1'b1, 32'h20);
		@(posedge clk_i);
		offer(4'd11, 1'b1);
		bus(IE_FIRST_OFF, 1'b1, 32'h3f);
		src <= '0;
		// Nesting: equal level waits, higher preempts
		hold <= 1'b0;
		bus(IP_FIRST_OFF, 1'b1, 32'h0);
		bus(IP_SECOND_OFF, 1'b1, 32'h18);
		bus(IE_FIRST_OFF, 1'b1, 32'h80);
		bus(IE_SECOND_OFF, 1'b1, 32'hff);
		src[6] <= 1'b1;
		offer(4'd6, 1'b0);
		src <= 14'h0080;
		quiet(4);
		src[9] <= 1'b1;
		offer(4'd9, 1'b1);
		src <= 14'h0480;
		quiet(4);
		leave();
		offer(4'd10, 1'b1);
		src <= 14'h0080;
		leave();
		quiet(2);
		leave();
		offer(4'd7, 1'b0);
		src <= '0;
		leave();
		// Sticky status, mask and level output from both serial flags
		bus(STATUS_OFF, 1'b1, 32'h3fff);
		rd(STATUS_OFF, '0);
		src[4] <= 1'b1;
		repeat (2) @(posedge clk_i);
		rd(STATUS_OFF, 32'h10);
		chk(irq, 1'b0, "masked irq");
		bus(MASK_OFF, 1'b1, 32'h10);
		chk(irq, 1'b1, "unmasked irq");
		bus(STATUS_OFF, 1'b1, 32'h10);
		chk(irq, 1'b0, "cleared irq");
		src[4] <= 1'b0;
		// Let the serial request fall first so the receive flag makes a fresh edge
		@(posedge clk_i);
		rx <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk(irq, 1'b1, "receive flag irq");
		bus(MASK_OFF, 1'b1, 32'h0);
		chk(irq, 1'b0, "mask off irq");
		rd(MASK_OFF, '0);
		final_report();
	end
endmodule : tb_top
